// ==== testbench/acs_cmp_model.sv ====
// Purpose: comparator model on the far side
// Assumes: level fixed for a whole conversion
// Notes:   toggles when idle so stale values never look valid
`timescale 1ns/1ns
`default_nettype none
module acs_cmp_model (input wire logic ref_clk, busy, lvl, output logic cmp_hi);
  initial cmp_hi = 1'b0;
  // steady level while converting keeps timing met
  always @(posedge ref_clk) cmp_hi <= busy ? lvl : ~cmp_hi;
endmodule // acs_cmp_model
`default_nettype wire

// ==== testbench/acs_props.sv ====
// Purpose: port checker for acs_seq
// Assumes: one clock, rstn active low
// Notes:   bound from the tb file
`timescale 1ns/1ns
`default_nettype none
module acs_props (input wire logic ref_clk, rstn, converter_enable, clock_select_rc, start_write, stop_write,
  compare_trigger, sleep_mode, interrupt_enable, conversion_active_flag, conversion_done_flag, analog_powered,
  wake_request, period_counter_reset);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // accepted start on the system clock
  sequence go_s;
    start_write && converter_enable && !conversion_active_flag && !clock_select_rc && !sleep_mode;
  endsequence
  sequence trig_s;
    compare_trigger && converter_enable && !conversion_active_flag;
  endsequence
  busy_hold_a: assert property (go_s |=> conversion_active_flag [*8])
    else $error("busy missing after start");
  start_refused_a: assert property (start_write && !converter_enable && !conversion_active_flag |=> !conversion_active_flag)
    else $error("start accepted while disabled");
  done_set_a: assert property ($fell(conversion_active_flag) && !$past(stop_write) && !$past(sleep_mode)
    |-> conversion_done_flag) else $error("done flag missing at completion");
  power_off_a: assert property (!converter_enable ##1 !converter_enable |-> !analog_powered)
    else $error("converter powered while disabled");
  trigger_start_a: assert property (trig_s |=> period_counter_reset ##[0:5] conversion_active_flag)
    else $error("trigger did not start");
  early_stop_a: assert property (stop_write && conversion_active_flag |=> !conversion_active_flag [*2])
    else $error("stop ignored");
  sleep_off_a: assert property (sleep_mode && !clock_select_rc && conversion_active_flag
    |-> ##[1:2] (!conversion_active_flag && !analog_powered)) else $error("sleep did not abort");
  wake_sleep_a: assert property (wake_request |-> $past(interrupt_enable) && $past(sleep_mode))
    else $error("wake without enabled interrupt in sleep");
  rc_sleep_a: assert property ($fell(conversion_active_flag) && sleep_mode && clock_select_rc && !interrupt_enable
    |-> ##[0:2] !analog_powered) else $error("converter left on after sleep completion");
endmodule // acs_props
`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for acs_seq
// Assumes: inputs driven at falling edge
// Notes:   constant comparator level gives all-ones or zero
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic ref_clk = 0, rstn = 0, en = 0, rc = 0, st = 0, sp = 0, tr = 0, sl = 0, ie = 0, dc = 0, lvl = 0;
  wire logic cmp, busy, done, pw, wk, pcr;
  wire logic [7:0] hb, lb;
  int n_mismatch = 0, samples_checked = 0, k;
  logic [17:0] row [4] = '{{2'b01, 16'h03ff}, {2'b00, 16'h0000}, {2'b11, 16'h03ff}, {2'b10, 16'h0000}};
  acs_seq dut (.ref_clk(ref_clk), .rstn(rstn), .converter_enable(en), .clock_select_rc(rc), .start_write(st),
    .stop_write(sp), .compare_trigger(tr), .sleep_mode(sl), .interrupt_enable(ie), .done_clear(dc), .cmp_hi(cmp),
    .conversion_active_flag(busy), .conversion_done_flag(done), .result_high_byte(hb), .result_low_byte(lb),
    .analog_powered(pw), .wake_request(wk), .period_counter_reset(pcr));
  acs_cmp_model pm (.ref_clk(ref_clk), .busy(busy), .lvl(lvl), .cmp_hi(cmp));
  initial forever #2 ref_clk = ~ref_clk;
  task chk(input logic [23:0] seen, input logic [23:0] exp, input string nm);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // one-cycle start strobe, software or trigger
  task go(input logic trig);
    @(negedge ref_clk) {tr, st} = trig ? 2'b10 : 2'b01;
    @(negedge ref_clk) {tr, st} = 2'b00;
  endtask
  // bounded wait for done, then clear it
  task fin(input logic [15:0] exp);
    for (int i = 0; i < 100 && done !== 1'b1; i++) cyc(1);
    chk({busy, done}, 2'b01, "completion flags");
    chk({hb, lb}, exp, "result");
    @(negedge ref_clk) dc = 1;
    @(negedge ref_clk) dc = 0;
  endtask
  initial begin
    cyc(3);
    rstn = 1;
    cyc(4);
    chk({busy, done, pw}, 0, "reset flags");
    go(0);
    cyc(3);
    chk({busy, hb, lb}, 0, "start while off");
    en = 1;
    cyc(2); // start in a later write than enable
    for (k = 0; k < 4; k++) begin
      {rc, lvl} = row[k][17:16];
      go(0);
      cyc(5);
      chk(busy, 1, "busy");
      fin(row[k][15:0]);
    end
    rc = 0;
    go(1);
    cyc(1);
    chk(busy, 1, "trigger busy");
    fin(16'h0000);
    lvl = 1;
    go(0);
    cyc(12);
    sp = 1;
    cyc(1);
    sp = 0;
    cyc(2);
    chk({busy, hb, lb}, 16'h03ff, "partial result");
    go(0);
    cyc(8);
    sl = 1;
    cyc(3);
    chk({busy, pw}, 0, "sleep abort");
    sl = 0;
    cyc(1);
    {rc, ie} = 2'b11;
    sl = 1;
    go(0);
    fin(16'h03ff);
    ie = 0;
    go(0);
    fin(16'h03ff);
    chk(pw, 0, "off after sleep completion");
    sl = 0;
    cyc(1);
    go(0);
    cyc(5);
    rstn = 0;
    cyc(1);
    chk({busy, done, pw, hb, lb}, 0, "mid-run reset");
    rstn = 1;
    cyc(4);
    close_out;
  end
  // hang guard, several times the expected run
  initial begin
    #20000;
    n_mismatch++;
    close_out;
  end
endmodule // tb
bind acs_seq acs_props u_props (.*);
`default_nettype wire

// ==== verilog/acs_defs.vh ====
// Purpose: constants for the conversion sequencer
// Assumes: 250 MHz ref_clk
// Notes:   widths and counts are defaults only
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH
`define ACS_RES_BITS      10
`define ACS_RESULT_RESET  10'h000
`define ACS_INSTR_NS      16
`define ACS_CLK_NS        4
`define ACS_INSTR_CYCLES  ((`ACS_INSTR_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_BIT_DIV       4
`define ACS_SRC_SYS       1'b0
`define ACS_SRC_RC        1'b1
`endif

// ==== verilog/acs_sar_core.v ====
// Purpose: successive-approximation bit resolver
// Assumes: comparator input settles within one bit period
// Notes:   partial results fill unresolved bits with the last resolved bit
`timescale 1ns/1ns
`default_nettype none
module acs_sar_core #(
  parameter WIDTH = 10
) (
  input  wire             ref_clk,
  input  wire             rst_n,
  input  wire             clear,
  input  wire             step,
  input  wire             cmp_hi,
  output reg  [WIDTH-1:0] bits_reg,
  output reg  [WIDTH-1:0] mask_reg,
  output wire             last_bit
);
  // trial bit walks from msb down
  assign last_bit = mask_reg[0];

  // resolve one bit per step
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bits_reg <= {WIDTH{1'b0}};
      mask_reg <= {WIDTH{1'b0}};
    end else if (clear) begin
      bits_reg <= {WIDTH{1'b0}};
      mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (step) begin
      bits_reg <= bits_reg | (cmp_hi ? mask_reg : {WIDTH{1'b0}});
      mask_reg <= mask_reg >> 1;
    end
  end
endmodule // acs_sar_core
`default_nettype wire

// ==== verilog/acs_seq.v ====
// Purpose: conversion sequencer for a successive-approximation converter
// Assumes: control bits are plain ports, writes are one-cycle strobes
// Notes:   one instruction cycle lasts ACS_INSTR_CYCLES clocks
//          results are right aligned in the two result bytes
//          a stop before the first bit step leaves a zero result, except in the rc delay (old result) and the first sys-clock conv cycle (stale sar word)
// Operation
// (R1) the converter runs only while converter_enable is one.
// (R2) writing the busy flag to one starts a conversion and it reads one meanwhile.
// (R3) software should set the start in a later write than the enable.
// (R4) on completion busy clears, done sets and both result bytes load.
// (R5) clearing busy early stops and stores the partial result; a stop in the rc delay keeps the old result.
// (R6) unresolved bits copy the last resolved bit on early stop.
// (R7) reset returns every register to reset, converter off, conversion aborted.
// (R8) conversion continues in sleep only with the dedicated rc clock.
// (R9) with the rc clock the start waits one more instruction cycle.
// (R10) with interrupt enabled, completion in sleep wakes the device.
// (R11) with interrupt disabled, completion in sleep turns converter off, enable stays.
// (R12) with another clock, sleep aborts and turns off, enable stays.
// (R13) the compare trigger sets busy and resets the period counter.
// (R14) software must meet timing when using the hardware trigger.
// (R15) a start while disabled is ignored and results are kept.
`timescale 1ns/1ns
`default_nettype none
`include "acs_defs.vh"
module acs_seq #(
  parameter WIDTH   = `ACS_RES_BITS,
  parameter BIT_DIV = `ACS_BIT_DIV
) (
  input  wire             ref_clk,
  input  wire             rstn,
  input  wire             converter_enable,
  input  wire             clock_select_rc,
  input  wire             start_write,
  input  wire             stop_write,
  input  wire             compare_trigger,
  input  wire             sleep_mode,
  input  wire             interrupt_enable,
  input  wire             done_clear,
  input  wire             cmp_hi,
  output wire             conversion_active_flag,
  output reg              conversion_done_flag,
  output reg  [7:0]       result_high_byte,
  output reg  [7:0]       result_low_byte,
  output reg              analog_powered,
  output reg              wake_request,
  output reg              period_counter_reset
);
  // idle: waiting for an accepted start
  // delay: one extra instruction cycle before converting on the rc clock
  // conv: one trial bit every BIT_DIV clocks, msb first
  // off: converter unpowered in sleep until woken or disabled
  localparam S_IDLE  = 4'b0001;
  localparam S_DELAY = 4'b0010;
  localparam S_CONV  = 4'b0100;
  localparam S_OFF   = 4'b1000;
  localparam DIVW    = 8;
  localparam integer    DIV_LAST_I = BIT_DIV - 1;
  localparam integer    DLY_LAST_I = `ACS_INSTR_CYCLES - 1;
  localparam [DIVW-1:0] DIV_LAST   = DIV_LAST_I[DIVW-1:0];
  localparam [DIVW-1:0] DLY_LAST   = DLY_LAST_I[DIVW-1:0];

  // reset release, sequencer state and sar core view
  reg  [1:0]       rst_sync_reg;
  wire             rst_n = rst_sync_reg[1];
  reg  [3:0]       state_reg;
  reg  [DIVW-1:0]  div_reg;
  reg              clear_sar;
  wire             bit_step;
  wire [WIDTH-1:0] sar_bits;
  wire [WIDTH-1:0] sar_mask;
  wire             sar_last;
  wire [WIDTH-1:0] partial;
  wire [WIDTH-1:0] final_word;
  wire             sleep_abort;
  wire             last_step;

  // reset release through two flops
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  // fill every bit from the trial bit down with the bit just above it;
  // with the trial bit still at the msb nothing is resolved and the word is zero
  function [WIDTH-1:0] fill_partial;
    input [WIDTH-1:0] bits;
    input [WIDTH-1:0] mask;
    reg   [WIDTH-1:0] word;
    reg               below;
    integer           n;
    begin
      word  = bits;
      below = mask[WIDTH-1];
      for (n = WIDTH - 2; n >= 0; n = n - 1) begin
        below = below | mask[n];
        if (below)
          word[n] = word[n+1]; // [R6]
      end
      fill_partial = word;
    end
  endfunction

  // current trial bit settled by the comparator
  function [WIDTH-1:0] settle_bit;
    input [WIDTH-1:0] bits;
    input [WIDTH-1:0] mask;
    input             hi;
    begin
      settle_bit = hi ? (bits | mask) : bits;
    end
  endfunction

  // right-align a result in the two result bytes
  function [15:0] pad_result;
    input [WIDTH-1:0] word;
    begin
      pad_result = {{(16-WIDTH){1'b0}}, word};
    end
  endfunction

  // words offered to the result registers
  assign partial    = fill_partial(sar_bits, sar_mask); // [R6]
  assign final_word = settle_bit(sar_bits, sar_mask, cmp_hi);
  // sleep without the rc clock kills a running conversion
  assign sleep_abort = sleep_mode && (clock_select_rc != `ACS_SRC_RC); // [R12]
  // the final trial bit resolves on this step
  assign last_step   = bit_step && sar_last;

  // start sources and busy decode
  wire start_req = start_write | compare_trigger;
  wire any_start = converter_enable & start_req; // [R15]
  assign conversion_active_flag = (state_reg == S_DELAY) | (state_reg == S_CONV); // [R2]
  // one bit step at the end of each divider period
  assign bit_step = (state_reg == S_CONV) && (div_reg == DIV_LAST);

  // bit resolver
  acs_sar_core #(
    .WIDTH (WIDTH)
  ) u_core (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clear    (clear_sar),
    .step     (bit_step),
    .cmp_hi   (cmp_hi),
    .bits_reg (sar_bits),
    .mask_reg (sar_mask),
    .last_bit (sar_last)
  );

  // conversion sequence
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // everything back to reset, conversion dropped
      state_reg            <= S_IDLE; // [R7]
      div_reg              <= {DIVW{1'b0}};
      clear_sar            <= 1'b0;
      conversion_done_flag <= 1'b0;
      result_high_byte     <= 8'h00;
      result_low_byte      <= 8'h00;
      analog_powered       <= 1'b0;
      wake_request         <= 1'b0;
      period_counter_reset <= 1'b0;
    end else begin
      clear_sar            <= 1'b0;
      wake_request         <= 1'b0;
      // trigger pulse also restarts the period counter
      period_counter_reset <= compare_trigger & converter_enable; // [R13]
      if (done_clear)
        conversion_done_flag <= 1'b0;
      analog_powered <= converter_enable && (state_reg != S_OFF); // [R1]
      case (state_reg)
        S_IDLE: begin
          // only an enabled start is taken
          if (any_start) begin
            div_reg   <= {DIVW{1'b0}};
            clear_sar <= 1'b1;
            if (clock_select_rc == `ACS_SRC_RC)
              state_reg <= S_DELAY; // [R9]
            else
              state_reg <= S_CONV;
          end
        end
        S_DELAY: begin
          // a stop or a disable before converting returns to idle
          if (!converter_enable || stop_write)
            state_reg <= S_IDLE;
          else if (div_reg == DLY_LAST) begin
            div_reg   <= {DIVW{1'b0}};
            state_reg <= S_CONV;
          end else
            div_reg <= div_reg + 8'h01;
        end
        S_CONV: begin
          div_reg <= (div_reg == DIV_LAST) ? {DIVW{1'b0}} : div_reg + 8'h01;
          // priority: disable, sleep abort, software stop, completion
          if (!converter_enable)
            state_reg <= S_IDLE; // [R1]
          else if (sleep_abort)
            state_reg <= S_OFF; // [R12]
          else if (stop_write) begin
            {result_high_byte, result_low_byte} <= pad_result(partial); // [R5]
            state_reg <= S_IDLE;
          end else if (last_step) begin
            {result_high_byte, result_low_byte} <= pad_result(final_word); // [R4]
            conversion_done_flag <= 1'b1; // [R4]
            if (sleep_mode && interrupt_enable)
              wake_request <= 1'b1; // [R10]
            state_reg <= (sleep_mode && !interrupt_enable) ? S_OFF : S_IDLE; // [R11] [R8]
          end
        end
        S_OFF: begin
          // stays off through sleep while enable still reads set
          if (!converter_enable || !sleep_mode)
            state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // acs_seq
`default_nettype wire
